// ===== rtl/fvc_pkg.sv
package fvc_pkg;
  localparam logic [4:0] VERIFY_CODE = 5'h16;
  localparam logic [5:0] WRITE_CODE = 6'h05;
  localparam logic [5:0] WRDEL_CODE = 6'h09;
  localparam logic [5:0] FORMAT_CODE = 6'h0d;
  localparam logic [7:0] VERSION_CODE = 8'h10;
  localparam logic [7:0] RECAL_CODE = 8'h07;
  localparam logic [7:0] SENSE_CODE = 8'h08;
  localparam logic [7:0] INVALID_STATUS = 8'h80;
  localparam logic [7:0] SEEK_END_STATUS = 8'h20;
  localparam logic [3:0] RW_CMD_BYTES = 4'h9;
  localparam logic [3:0] FMT_CMD_BYTES = 4'h6;
  localparam logic [3:0] RESULT_BYTES = 4'h7;
  localparam logic [1:0] FMT_ID_BYTES = 2'h3;
  localparam logic [7:0] MAX_STEPS = 8'hff;
  typedef enum {
    FVC_IDLE, FVC_PARAM, FVC_EXEC, FVC_FMTID, FVC_STEP, FVC_RESULT
  } fvc_state_t;
endpackage : fvc_pkg

// ===== rtl/fvc_verify_write_format.sv
`timescale 1ns/100ps
module fvc_buf2 #(
  parameter int W = 8
) (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [W-1:0] inData, // Write data
  input wire logic inValid, // Write valid
  output logic inReady, // Space available
  output logic [W-1:0] outData, // Head word
  output logic outValid, // Head valid
  input wire logic outReady // Drain accept
);
  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic [1:0] count, next_count;
  logic wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic doWr, doRd;
  always_comb begin
    doWr = inValid && (count != 2'h2);
    doRd = (count != 2'h0) && outReady;
    next_mem = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (doWr) begin
      next_mem[wrPtr] = inData;
      next_wrPtr = ~wrPtr;
    end
    if (doRd) begin
      next_rdPtr = ~rdPtr;
    end
    if (doWr && !doRd) begin
      next_count = count + 2'h1;
    end else if (doRd && !doWr) begin
      next_count = count - 2'h1;
    end
  end
  // Head word and valid are registered so the drive side sees flop outputs
  always_ff @(posedge mclk) begin
    mem <= next_mem;
    outData <= next_mem[next_rdPtr];
    if (sys_rst) begin
      count <= 2'h0;
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      outValid <= 1'b0;
    end else begin
      count <= next_count;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      outValid <= (next_count != 2'h0);
    end
  end
  assign inReady = (count != 2'h2);
endmodule : fvc_buf2

module fvc_verify_write_format
  import fvc_pkg::*;
#(
  parameter logic [7:0] CONTROLLER_TYPE = 8'h5a // Arbitrary type code
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [7:0] hostWrData, // Command/param/format byte
  input wire logic hostWrValid, // Host offers a byte
  output logic hostWrReady, // Controller accepts byte
  output logic [7:0] hostRdData, // Result byte
  output logic hostRdValid, // Result byte available
  input wire logic hostRdReady, // Host takes result byte
  output logic [7:0] diskData, // Sector data to drive
  output logic diskDataValid, // Sector data strobe
  input wire logic diskDataReady, // Drive accepts data
  output logic verifyStart, // Start sector check pulse
  input wire logic sectorDone, // Drive finished sector op
  input wire logic [7:0] driveStatus0, // Status zero from media op
  input wire logic [7:0] driveStatus1, // Status one
  input wire logic [7:0] driveStatus2, // Status two
  input wire logic [7:0] sectorBytes, // Bytes per transfer, minus one
  input wire logic track0, // Selected head at track 0
  output logic stepPulse, // Step head outward
  output logic [1:0] driveSel, // Selected drive
  output logic headSel, // Selected head
  output logic doubleDensity, // Density of current command
  output logic multiTrack, // Multi-track of current command
  output logic skipDeleted, // Skip-deleted of current command
  output logic endCount, // End-count of verify
  output logic deletedMark, // Write deleted data mark
  output logic intReq // Interrupt after recalibrate
);
  import fvc_pkg::*;
  typedef enum {FVC_C_VER, FVC_C_WR, FVC_C_FMT, FVC_C_OTHER} fvc_cmd_t;
  fvc_state_t state, next_state;
  fvc_cmd_t cmd, next_cmd;
  logic [7:0] par [9];
  logic [7:0] next_par [9];
  logic [7:0] res [7];
  logic [7:0] next_res [7];
  logic [3:0] idx, next_idx, resLen, next_resLen;
  logic [7:0] cnt, next_cnt, present_cylinder, next_pcn, sts0, next_sts0;
  logic [7:0] secLeft, next_secLeft;
  logic [1:0] fmtIdx, next_fmtIdx;
  logic intPend, next_intPend;
  logic dataIn, next_dataIn;
  logic next_verifyStart, next_stepPulse, next_intReq;
  logic wrTake, rdTake, bufReady, bufValid, bufWr;
  logic [7:0] bufData;
  logic rdValid;
  assign wrTake = hostWrValid && hostWrReady;
  assign rdTake = hostRdValid && hostRdReady;
  assign bufWr = wrTake && state == FVC_EXEC && cmd == FVC_C_WR;
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_par = par;
    next_res = res;
    next_idx = idx;
    next_resLen = resLen;
    next_cnt = cnt;
    next_pcn = present_cylinder;
    next_sts0 = sts0;
    next_secLeft = secLeft;
    next_fmtIdx = fmtIdx;
    next_intPend = intPend;
    next_dataIn = dataIn;
    next_verifyStart = 1'b0;
    next_stepPulse = 1'b0;
    next_intReq = intPend;
    case (state)
      FVC_IDLE: begin
        if (wrTake) begin
          next_par[0] = hostWrData;
          next_idx = 4'h1;
          if (hostWrData[4:0] == VERIFY_CODE) begin
            next_cmd = FVC_C_VER;
            next_state = FVC_PARAM;
          end else if (hostWrData[5:0] == WRITE_CODE
              || hostWrData[5:0] == WRDEL_CODE) begin
            next_cmd = FVC_C_WR;
            next_state = FVC_PARAM;
          end else if (hostWrData[5:0] == FORMAT_CODE && !hostWrData[7]) begin
            next_cmd = FVC_C_FMT;
            next_state = FVC_PARAM;
          end else if (hostWrData == RECAL_CODE) begin
            next_cmd = FVC_C_OTHER;
            next_state = FVC_PARAM;
          end else if (hostWrData == VERSION_CODE) begin
            next_res[0] = CONTROLLER_TYPE;
            next_resLen = 4'h1;
            next_idx = 4'h0;
            next_state = FVC_RESULT;
          end else if (hostWrData == SENSE_CODE && intPend) begin
            next_res[0] = sts0;
            next_res[1] = present_cylinder;
            next_resLen = 4'h2;
            next_idx = 4'h0;
            next_intPend = 1'b0;
            next_intReq = 1'b0;
            next_state = FVC_RESULT;
          end else begin
            next_res[0] = INVALID_STATUS;
            next_resLen = 4'h1;
            next_idx = 4'h0;
            next_state = FVC_RESULT;
          end
        end
      end
      FVC_PARAM: begin
        if (wrTake) begin
          next_par[idx] = hostWrData;
          next_idx = idx + 4'h1;
          if (par[0] == RECAL_CODE) begin
            next_cnt = MAX_STEPS;
            next_intPend = 1'b0;
            next_intReq = 1'b0;
            next_state = FVC_STEP;
          end else if (cmd == FVC_C_FMT && idx == FMT_CMD_BYTES - 4'h1) begin
            next_secLeft = par[3];
            next_fmtIdx = 2'h0;
            next_state = FVC_FMTID;
          end else if (cmd != FVC_C_FMT && idx == RW_CMD_BYTES - 4'h1) begin
            next_cnt = sectorBytes;
            next_dataIn = 1'b0;
            next_verifyStart = (cmd == FVC_C_VER);
            next_state = FVC_EXEC;
          end
        end
      end
      FVC_EXEC: begin
        // Write: count host data bytes forwarded; verify: wait for drive check
        // Count holds bytes still owed minus one; the last byte closes the data phase
        if (cmd == FVC_C_WR && wrTake) begin
          if (cnt == 8'h0) begin
            next_dataIn = 1'b1;
          end else begin
            next_cnt = cnt - 8'h1;
          end
        end
        if (sectorDone && (cmd == FVC_C_VER || dataIn)) begin
          next_res[0] = driveStatus0;
          next_res[1] = driveStatus1;
          next_res[2] = driveStatus2;
          next_res[3] = par[2];
          next_res[4] = par[3];
          next_res[5] = par[4];
          next_res[6] = par[5];
          next_resLen = RESULT_BYTES;
          next_idx = 4'h0;
          next_state = FVC_RESULT;
        end
      end
      FVC_FMTID: begin
        if (wrTake) begin
          next_fmtIdx = fmtIdx + 2'h1;
          if (fmtIdx == FMT_ID_BYTES) begin
            next_secLeft = secLeft - 8'h1;
            if (secLeft <= 8'h1) begin
              next_res[0] = driveStatus0;
              next_res[1] = driveStatus1;
              next_res[2] = driveStatus2;
              next_res[3] = 8'h00;
              next_res[4] = 8'h00;
              next_res[5] = 8'h00;
              next_res[6] = 8'h00;
              next_resLen = RESULT_BYTES;
              next_idx = 4'h0;
              next_state = FVC_RESULT;
            end
          end
        end
      end
      FVC_STEP: begin
        if (track0 || cnt == 8'h0) begin
          next_pcn = 8'h00;
          next_sts0 = SEEK_END_STATUS | {6'h00, par[1][1:0]};
          next_intPend = 1'b1;
          next_intReq = 1'b1;
          next_state = FVC_IDLE;
        end else if (!stepPulse) begin
          next_stepPulse = 1'b1;
          next_cnt = cnt - 8'h1;
        end
      end
      FVC_RESULT: begin
        if (rdTake) begin
          next_idx = idx + 4'h1;
          if (idx == resLen - 4'h1) begin
            next_state = FVC_IDLE;
          end
        end
      end
      default: next_state = FVC_IDLE;
    endcase
  end
  always_comb begin
    rdValid = (next_state == FVC_RESULT);
  end
  always_ff @(posedge mclk) begin
    par <= next_par;
    res <= next_res;
    if (sys_rst) begin
      state <= FVC_IDLE;
      cmd <= FVC_C_OTHER;
      idx <= 4'h0;
      resLen <= 4'h0;
      cnt <= 8'h00;
      present_cylinder <= 8'h00;
      sts0 <= 8'h00;
      secLeft <= 8'h00;
      fmtIdx <= 2'h0;
      intPend <= 1'b0;
      dataIn <= 1'b0;
      verifyStart <= 1'b0;
      stepPulse <= 1'b0;
      intReq <= 1'b0;
      hostRdValid <= 1'b0;
      hostRdData <= 8'h00;
      hostWrReady <= 1'b0;
      driveSel <= 2'h0;
      headSel <= 1'b0;
      doubleDensity <= 1'b0;
      multiTrack <= 1'b0;
      skipDeleted <= 1'b0;
      endCount <= 1'b0;
      deletedMark <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      idx <= next_idx;
      resLen <= next_resLen;
      cnt <= next_cnt;
      present_cylinder <= next_pcn;
      sts0 <= next_sts0;
      secLeft <= next_secLeft;
      fmtIdx <= next_fmtIdx;
      intPend <= next_intPend;
      dataIn <= next_dataIn;
      verifyStart <= next_verifyStart;
      stepPulse <= next_stepPulse;
      intReq <= next_intReq;
      hostRdValid <= rdValid && !(rdTake && next_idx == resLen);
      hostRdData <= next_res[next_idx[2:0]];
      // Ready is a cycle late, so after each buffered byte one cycle passes
      // before the next; a full buffer or a finished data phase refuses bytes
      hostWrReady <= (next_state == FVC_IDLE || next_state == FVC_PARAM
          || next_state == FVC_FMTID
          || (next_state == FVC_EXEC && next_cmd == FVC_C_WR && bufReady && !bufWr
          && !next_dataIn));
      driveSel <= next_par[1][1:0];
      headSel <= next_par[1][2] && (next_par[0] != RECAL_CODE);
      doubleDensity <= next_par[0][6];
      multiTrack <= next_par[0][7] && next_cmd != FVC_C_FMT;
      skipDeleted <= next_par[0][5] && next_cmd == FVC_C_VER;
      endCount <= next_par[1][7] && next_cmd == FVC_C_VER;
      deletedMark <= next_par[0][5:0] == WRDEL_CODE;
    end
  end
  fvc_buf2 #(.W(8)) dataBuf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inData(hostWrData),
    .inValid(bufWr),
    .inReady(bufReady),
    .outData(bufData),
    .outValid(bufValid),
    .outReady(diskDataReady)
  );
  assign diskData = bufData;
  assign diskDataValid = bufValid;
endmodule : fvc_verify_write_format

// ===== bench/fvc_verify_write_format_asserts.sv
`timescale 1ns/100ps
module fvc_verify_write_format_asserts
  import fvc_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] hostWrData, // Host byte
  input wire logic hostWrValid, // Host offers
  input wire logic hostWrReady, // Byte accepted
  input wire logic [7:0] hostRdData, // Result byte
  input wire logic hostRdValid, // Result ready
  input wire logic hostRdReady, // Host takes
  input wire logic [7:0] diskData, // Drive byte
  input wire logic diskDataValid, // Drive strobe
  input wire logic diskDataReady, // Drive accepts
  input wire logic verifyStart, // Check start
  input wire logic track0, // At track 0
  input wire logic stepPulse, // Step out
  input wire logic intReq // Interrupt
);
  import fvc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic clrTake, recalSeen;
  // A new recalibrate clears a pending interrupt as its drive byte is taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      recalSeen <= 1'b0;
    end else if (hostWrValid && hostWrReady) begin
      recalSeen <= (hostWrData == RECAL_CODE);
    end
  end
  assign clrTake = hostWrValid && hostWrReady
      && (hostWrData == SENSE_CODE || recalSeen);
  result_hold_a: assert property (hostRdValid && !hostRdReady
      |=> hostRdValid && $stable(hostRdData))
    else $error("result byte changed before it was taken");
  result_refuse_a: assert property (hostRdValid |-> !hostWrReady)
    else $error("host byte accepted during result phase");
  disk_hold_a: assert property (diskDataValid && !diskDataReady
      |=> diskDataValid && $stable(diskData))
    else $error("sector byte lost while drive stalls");
  verify_nodata_a: assert property (verifyStart |=> (!diskDataValid && !hostWrReady) [*3])
    else $error("data moved during sector check");
  step_stop_a: assert property ($past(track0) |-> !stepPulse)
    else $error("step issued at track zero");
  int_nores_a: assert property ($rose(intReq) |-> !hostRdValid)
    else $error("result offered after head retract");
  int_hold_a: assert property (intReq && !clrTake |=> intReq)
    else $error("interrupt dropped without sense command");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst
      |=> !hostWrReady && !hostRdValid && !intReq && !stepPulse)
    else $error("outputs not cleared by reset");
  cover property ($rose(intReq));
  cover property (verifyStart);
  cover property (diskDataValid && diskDataReady);
  cover property (hostRdValid && hostRdReady);
endmodule : fvc_verify_write_format_asserts

bind fvc_verify_write_format fvc_verify_write_format_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .hostWrData(hostWrData), .hostWrValid(hostWrValid), .hostWrReady(hostWrReady),
  .hostRdData(hostRdData), .hostRdValid(hostRdValid), .hostRdReady(hostRdReady),
  .diskData(diskData), .diskDataValid(diskDataValid), .diskDataReady(diskDataReady),
  .verifyStart(verifyStart), .track0(track0), .stepPulse(stepPulse), .intReq(intReq));

// ===== bench/fvc_drive_model.sv
`timescale 1ns/100ps
module fvc_drive_model (
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic [7:0] diskData, // Sector byte
  input wire logic diskDataValid, // Byte offered
  output logic diskDataReady, // Byte taken
  input wire logic verifyStart, // Check start
  input wire logic [7:0] sectorBytes, // Bytes minus one
  output logic sectorDone, // Operation done
  input wire logic stepPulse, // Step out
  output logic track0, // At track 0
  output logic [7:0] rxLast, // Last byte seen
  output logic [7:0] rxTotal // Bytes seen
);
  logic [1:0] phase;
  logic [8:0] rxCount;
  logic [3:0] vWait;
  logic [7:0] steps;
  // Stalls every other pair of cycles so the buffer must hold words
  assign diskDataReady = phase[1];
  // Head reaches track zero after three outward steps
  assign track0 = (steps >= 8'h03);
  always @(posedge mclk) begin
    phase <= phase + 2'h1;
    sectorDone <= 1'b0;
    if (sys_rst) begin
      phase <= 2'h0;
      rxCount <= 9'h000;
      rxTotal <= 8'h00;
      vWait <= 4'h0;
      steps <= 8'h00;
    end else begin
      if (stepPulse) steps <= steps + 8'h01;
      if (diskDataValid && diskDataReady) begin
        rxLast <= diskData;
        rxCount <= rxCount + 9'h001;
        rxTotal <= rxTotal + 8'h01;
      end
      if (rxCount == {1'b0, sectorBytes} + 9'h001) begin
        sectorDone <= 1'b1;
        rxCount <= 9'h000;
      end
      if (verifyStart) vWait <= 4'ha;
      else if (vWait != 4'h0) begin
        vWait <= vWait - 4'h1;
        sectorDone <= (vWait == 4'h1);
      end
    end
  end
endmodule : fvc_drive_model

// ===== bench/fvc_verify_write_format_tb.sv
`timescale 1ns/100ps
module fvc_verify_write_format_tb;
  import fvc_pkg::*;
  localparam logic [7:0] TYPE_CODE = 8'h3c; // Arbitrary type code
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] hostWrData = 8'h00;
  logic hostWrValid = 1'b0;
  logic hostRdReady = 1'b0;
  logic hostWrReady, hostRdValid, diskDataValid, diskDataReady, verifyStart, sectorDone;
  logic track0, stepPulse, headSel, doubleDensity, multiTrack, skipDeleted, endCount;
  logic deletedMark, intReq;
  logic [7:0] hostRdData, diskData, rxLast, rxTotal;
  logic [1:0] driveSel;
  logic [7:0] p [7] = '{8'h0a, 8'h01, 8'h03, 8'h02, 8'h09, 8'h1b, 8'hff};
  logic [7:0] f [5] = '{8'h04, 8'h02, 8'h02, 8'h1b, 8'he5};
  int errors = 0;
  int checks = 0;
  always #12.5 mclk = ~mclk;
  fvc_verify_write_format #(.CONTROLLER_TYPE(TYPE_CODE)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .hostWrData(hostWrData), .hostWrValid(hostWrValid), .hostWrReady(hostWrReady),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid), .hostRdReady(hostRdReady),
    .diskData(diskData), .diskDataValid(diskDataValid), .diskDataReady(diskDataReady),
    .verifyStart(verifyStart), .sectorDone(sectorDone), .driveStatus0(8'h41),
    .driveStatus1(8'h02), .driveStatus2(8'h04), .sectorBytes(8'h03), .track0(track0),
    .stepPulse(stepPulse), .driveSel(driveSel), .headSel(headSel),
    .doubleDensity(doubleDensity), .multiTrack(multiTrack), .skipDeleted(skipDeleted),
    .endCount(endCount), .deletedMark(deletedMark), .intReq(intReq));
  fvc_drive_model u_drv (.mclk(mclk), .sys_rst(sys_rst), .diskData(diskData),
    .diskDataValid(diskDataValid), .diskDataReady(diskDataReady), .verifyStart(verifyStart),
    .sectorBytes(8'h03), .sectorDone(sectorDone), .stepPulse(stepPulse), .track0(track0),
    .rxLast(rxLast), .rxTotal(rxTotal));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b);
    int n = 0;
    @(negedge mclk);
    hostWrData = b;
    hostWrValid = 1'b1;
    while (hostWrReady !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) errors++;
    @(negedge mclk);
    hostWrValid = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] exp);
    int n = 0;
    @(negedge mclk);
    while (hostRdValid !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) errors++;
    chk(hostRdData, exp);
    hostRdReady = 1'b1;
    @(negedge mclk);
    hostRdReady = 1'b0;
  endtask : rd
  task automatic st3();
    rd(8'h41);
    rd(8'h02);
    rd(8'h04);
  endtask : st3
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Whole sequence needs a few hundred cycles; allow far more
  initial begin
    #2000000;
    errors++;
    finish_test();
  end
  initial begin
    int n = 0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    wr(VERSION_CODE);
    rd(TYPE_CODE);
    $display("Version test done");
    wr({3'h7, VERIFY_CODE});
    wr(8'h85);
    for (int i = 2; i < 9; i++) wr(p[i-2]);
    st3();
    for (int i = 0; i < 4; i++) rd(p[i]);
    chk({5'h0, multiTrack, doubleDensity, skipDeleted}, 8'h07);
    chk({4'h0, endCount, headSel, driveSel}, 8'h0d);
    chk(rxTotal, 8'h00);
    $display("Verify test done");
    for (int k = 0; k < 2; k++) begin
      wr(k ? {2'h2, WRDEL_CODE} : {2'h1, WRITE_CODE});
      wr(8'h02);
      for (int i = 2; i < 9; i++) wr(p[i-2]);
      for (int d = 0; d < 4; d++) wr(8'hd0 + 8'(d));
      st3();
      for (int i = 0; i < 4; i++) rd(p[i]);
      chk(rxLast, 8'hd3);
      chk(rxTotal, 8'(4 * k + 4));
      chk({4'h0, deletedMark, multiTrack, doubleDensity, headSel}, k ? 8'h0c : 8'h02);
    end
    $display("Write tests done");
    wr({2'h1, FORMAT_CODE});
    foreach (f[i]) wr(f[i]);
    for (int s = 0; s < 8; s++) wr(8'(s));
    st3();
    repeat (4) rd(8'h00);
    chk({6'h0, doubleDensity, headSel}, 8'h03);
    $display("Format test done");
    wr(RECAL_CODE);
    wr(8'h01);
    while (intReq !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk({5'h0, hostRdValid, track0, intReq}, 8'h03);
    chk({6'h0, driveSel}, 8'h01);
    wr(SENSE_CODE);
    rd(8'h21);
    rd(8'h00);
    chk({7'h0, intReq}, 8'h00);
    wr(SENSE_CODE);
    rd(INVALID_STATUS);
    $display("Recalibrate test done");
    finish_test();
  end
endmodule : fvc_verify_write_format_tb
